// file: hw/capfs_pkg.sv
package capfs_pkg;

   // ==========================================================
   // Register map, byte addresses on the APB word grid
   // ==========================================================
   localparam logic [11:0] CAPFS_FUNC_OFS    = 12'h000;
   localparam logic [11:0] CAPFS_GPIO_OFS    = 12'h004;
   localparam logic [11:0] CAPFS_STATUS_OFS  = 12'h008;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CAPFS_FUNC_SEL_LSB     = 0;
   localparam int CAPFS_FUNC_CANCEL_BIT  = 8;
   localparam int CAPFS_GPIO_EN_LSB      = 0;
   localparam int CAPFS_GPIO_DIR_LSB     = 4;
   localparam int CAPFS_GPIO_OUT_LSB     = 8;
   localparam int CAPFS_ST_PIN_BIT       = 0;
   localparam int CAPFS_ST_SUSP_BIT      = 1;
   localparam int CAPFS_ST_VBUS_BIT      = 2;
   localparam int CAPFS_ST_CHG_BIT       = 3;
   localparam int CAPFS_ST_STAMP_BIT     = 4;
   localparam int CAPFS_ST_AWAKE_BIT     = 5;
   localparam int CAPFS_GPIO_PINS        = 4;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [3:0] CAPFS_GPIO_RST  = 4'h0;
   localparam logic       CAPFS_CANCEL_RST = 1'b0;
   localparam logic [31:0] CAPFS_ZERO_WORD = 32'h0000_0000;

   // ==========================================================
   // Pin function codes
   // ==========================================================
   typedef enum logic [3:0] {
      CAPFS_FN_TRISTATE       = 4'h0,
      CAPFS_FN_DRIVE_ONE      = 4'h1,
      CAPFS_FN_DRIVE_ZERO     = 4'h2,
      CAPFS_FN_POWER_ENABLE_N = 4'h3,
      CAPFS_FN_SLEEP_N        = 4'h4,
      CAPFS_FN_CLOCK_FAST     = 4'h5,
      CAPFS_FN_CLOCK_MID      = 4'h6,
      CAPFS_FN_CLOCK_SLOW     = 4'h7,
      CAPFS_FN_GPIO           = 4'h8,
      CAPFS_FN_CHARGER        = 4'h9,
      CAPFS_FN_CHARGER_N      = 4'hA,
      CAPFS_FN_WRITE_STROBE_N = 4'hB,
      CAPFS_FN_READ_STROBE_N  = 4'hC,
      CAPFS_FN_BUS_POWER      = 4'hD,
      CAPFS_FN_TIMESTAMP      = 4'hE,
      CAPFS_FN_STAY_AWAKE_N   = 4'hF
   } capfs_func_t;

   localparam capfs_func_t CAPFS_FUNC_RST = CAPFS_FN_TRISTATE;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } capfs_apb_req_t;

   typedef struct packed {
      logic        configured;
      logic        suspend_req;
      logic        charger_attached;
      logic        sof_pulse;
      logic        clock_out_fast;
      logic        clock_out_mid;
      logic        clock_out_slow;
      logic        bitbang_write_strobe_n;
      logic        bitbang_read_strobe_n;
   } capfs_core_t;

   typedef struct packed {
      capfs_func_t func;
      logic        cancel_sleep;
      logic [3:0]  gpio_en;
      logic [3:0]  gpio_dir;
      logic [3:0]  gpio_out;
      logic        stamp;
      logic        pin_out;
      logic        pin_oe_n;
      logic        bus_power;
      logic        suspended;
      logic [31:0] prdata;
      logic        pslverr;
   } capfs_state_t;

endpackage

// file: hw/capfs_aux_pin.sv
`timescale 1ns/1ps
// Operation
// - Function comes from stored config selection
// - Power enable low when configured, high suspended
// - Power enable is open drain only
// - Sleep indicator low in suspend, else high
// - Cancel option holds sleep high on charger
// - Clock output selected, stopped during suspend
// - GPIO mode per-pin enable, software controlled
// - Charger detect high while charger attached
// - Inverted charger detect pulls low, open drain
// - Write strobe mode outputs active-low strobe
// - Read strobe mode outputs active-low strobe
// - Bus power sense mode pin is input
// - Timestamp toggles pin per start-of-frame
// - Stay awake input low blocks suspend
module capfs_aux_pin
   import capfs_pkg::*;
#(
   parameter int PIN_INDEX = 3
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        usb_configured,
   input  wire logic        usb_suspend_req,
   input  wire logic        charger_attached,
   input  wire logic        sof_pulse,
   input  wire logic        clock_out_fast,
   input  wire logic        clock_out_mid,
   input  wire logic        clock_out_slow,
   input  wire logic        bitbang_write_strobe_n,
   input  wire logic        bitbang_read_strobe_n,
   input  wire logic        aux_pin_3_in,
   output      logic        aux_pin_3_out,
   output      logic        aux_pin_3_oe_n,
   output      logic        usb_suspended,
   output      logic        bus_power_sense
);

   // ==========================================================
   // Elaboration check
   // ==========================================================
   if (PIN_INDEX < 0 || PIN_INDEX >= CAPFS_GPIO_PINS) begin : g_bad_index
      $error("PIN_INDEX must select one of the four configurable pins");
   end
   if (CAPFS_GPIO_PINS != 4) begin : g_bad_pins
      $error("GPIO fields are four bits wide");
   end
   // Select field must stay clear of the cancel bit
   if (CAPFS_FUNC_SEL_LSB + 4 > CAPFS_FUNC_CANCEL_BIT) begin : g_bad_func
      $error("function field overlaps the cancel bit");
   end
   if (CAPFS_GPIO_OUT_LSB + CAPFS_GPIO_PINS > 32) begin : g_bad_gpio
      $error("GPIO output field leaves the word");
   end

   // ==========================================================
   // Decoding helpers
   // ==========================================================
   function automatic logic is_offset(input logic [11:0] addr,
                                      input logic [11:0] ofs);
      return addr == ofs;
   endfunction

   function automatic logic is_mapped(input logic [11:0] addr);
      return is_offset(addr, CAPFS_FUNC_OFS) || is_offset(addr, CAPFS_GPIO_OFS)
          || is_offset(addr, CAPFS_STATUS_OFS);
   endfunction

   // ==========================================================
   // Gathered inputs
   // ==========================================================
   capfs_apb_req_t apb;
   capfs_core_t    core;
   capfs_state_t   st_reg;
   capfs_state_t   st_next;

   logic           setup_phase;
   logic           write_phase;
   logic           stay_awake;
   logic           suspend_now;
   logic           selected_clock;
   logic           gpio_mine;
   logic [31:0]    func_word;
   logic [31:0]    gpio_word;
   logic [31:0]    status_word;
   logic [31:0]    merged_func;
   logic [31:0]    merged_gpio;

   assign apb.psel    = psel;
   assign apb.penable = penable;
   assign apb.pwrite  = pwrite;
   assign apb.paddr   = paddr;
   assign apb.pwdata  = pwdata;

   assign core.configured             = usb_configured;
   assign core.suspend_req            = usb_suspend_req;
   assign core.charger_attached       = charger_attached;
   assign core.sof_pulse              = sof_pulse;
   assign core.clock_out_fast         = clock_out_fast;
   assign core.clock_out_mid          = clock_out_mid;
   assign core.clock_out_slow         = clock_out_slow;
   assign core.bitbang_write_strobe_n = bitbang_write_strobe_n;
   assign core.bitbang_read_strobe_n  = bitbang_read_strobe_n;

   // ==========================================================
   // Bus phases
   // ==========================================================
   // Zero wait states: read data is latched in the setup cycle
   assign setup_phase = apb.psel && !apb.penable;
   assign write_phase = apb.psel && apb.penable && apb.pwrite;

   // ==========================================================
   // Suspend gating
   // ==========================================================
   assign stay_awake  = (st_reg.func == CAPFS_FN_STAY_AWAKE_N) && !aux_pin_3_in;
   assign suspend_now = core.suspend_req && !stay_awake;

   always_comb begin
      unique case (st_reg.func)
         CAPFS_FN_CLOCK_FAST: selected_clock = core.clock_out_fast;
         CAPFS_FN_CLOCK_MID:  selected_clock = core.clock_out_mid;
         default:             selected_clock = core.clock_out_slow;
      endcase
   end

   assign gpio_mine = st_reg.gpio_en[PIN_INDEX];

   // ==========================================================
   // Register words
   // ==========================================================
   always_comb begin
      func_word = CAPFS_ZERO_WORD;
      func_word[CAPFS_FUNC_SEL_LSB +: 4]  = st_reg.func;
      func_word[CAPFS_FUNC_CANCEL_BIT]    = st_reg.cancel_sleep;
      gpio_word = CAPFS_ZERO_WORD;
      gpio_word[CAPFS_GPIO_EN_LSB +: 4]   = st_reg.gpio_en;
      gpio_word[CAPFS_GPIO_DIR_LSB +: 4]  = st_reg.gpio_dir;
      gpio_word[CAPFS_GPIO_OUT_LSB +: 4]  = st_reg.gpio_out;
      status_word = CAPFS_ZERO_WORD;
      status_word[CAPFS_ST_PIN_BIT]       = aux_pin_3_in;
      status_word[CAPFS_ST_SUSP_BIT]      = st_reg.suspended;
      status_word[CAPFS_ST_VBUS_BIT]      = st_reg.bus_power;
      status_word[CAPFS_ST_CHG_BIT]       = core.charger_attached;
      status_word[CAPFS_ST_STAMP_BIT]     = st_reg.stamp;
      status_word[CAPFS_ST_AWAKE_BIT]     = stay_awake;
   end

   // Byte lanes honoured so software may touch the select, cancel or GPIO output field alone
   always_comb begin
      merged_func = func_word;
      merged_gpio = gpio_word;
      for (int b = 0; b < 4; b++) begin
         if (pstrb[b]) begin
            merged_func[8*b +: 8] = apb.pwdata[8*b +: 8];
            merged_gpio[8*b +: 8] = apb.pwdata[8*b +: 8];
         end
      end
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_next = st_reg;

      // Register writes take effect only at the access edge
      if (write_phase && is_offset(apb.paddr, CAPFS_FUNC_OFS)) begin
         st_next.func         = capfs_func_t'(merged_func[CAPFS_FUNC_SEL_LSB +: 4]);
         st_next.cancel_sleep = merged_func[CAPFS_FUNC_CANCEL_BIT];
      end
      if (write_phase && is_offset(apb.paddr, CAPFS_GPIO_OFS)) begin
         st_next.gpio_en  = merged_gpio[CAPFS_GPIO_EN_LSB +: 4];
         st_next.gpio_dir = merged_gpio[CAPFS_GPIO_DIR_LSB +: 4];
         st_next.gpio_out = merged_gpio[CAPFS_GPIO_OUT_LSB +: 4];
      end

      if (setup_phase) begin
         st_next.pslverr = !is_mapped(apb.paddr);
         if (is_offset(apb.paddr, CAPFS_FUNC_OFS)) begin
            st_next.prdata = func_word;
         end else if (is_offset(apb.paddr, CAPFS_GPIO_OFS)) begin
            st_next.prdata = gpio_word;
         end else if (is_offset(apb.paddr, CAPFS_STATUS_OFS)) begin
            st_next.prdata = status_word;
         end else begin
            st_next.prdata = CAPFS_ZERO_WORD;
         end
      end

      st_next.suspended = suspend_now;

      // Toggle flop runs only while the function is selected
      if (st_reg.func == CAPFS_FN_TIMESTAMP && core.sof_pulse) begin
         st_next.stamp = !st_reg.stamp;
      end

      st_next.bus_power = (st_reg.func == CAPFS_FN_BUS_POWER) && aux_pin_3_in;

      // Pad drive; oe_n low means the pad is driven
      st_next.pin_out  = 1'b0;
      st_next.pin_oe_n = 1'b1;
      unique case (st_reg.func)
         CAPFS_FN_TRISTATE: begin
            st_next.pin_oe_n = 1'b1;
         end
         CAPFS_FN_DRIVE_ONE: begin
            st_next.pin_out  = 1'b1;
            st_next.pin_oe_n = 1'b0;
         end
         CAPFS_FN_DRIVE_ZERO: begin
            st_next.pin_out  = 1'b0;
            st_next.pin_oe_n = 1'b0;
         end
         CAPFS_FN_POWER_ENABLE_N: begin
            // Never drive high: the external pull-up owns that level
            st_next.pin_out  = 1'b0;
            st_next.pin_oe_n = !(core.configured && !suspend_now);
         end
         CAPFS_FN_SLEEP_N: begin
            st_next.pin_oe_n = 1'b0;
            st_next.pin_out  = !suspend_now
                            || (st_reg.cancel_sleep && core.charger_attached);
         end
         CAPFS_FN_CLOCK_FAST,
         CAPFS_FN_CLOCK_MID,
         CAPFS_FN_CLOCK_SLOW: begin
            // Parked low in suspend rather than floating
            st_next.pin_oe_n = 1'b0;
            st_next.pin_out  = selected_clock && !suspend_now;
         end
         CAPFS_FN_GPIO: begin
            st_next.pin_out  = st_reg.gpio_out[PIN_INDEX];
            st_next.pin_oe_n = !(gpio_mine && st_reg.gpio_dir[PIN_INDEX]);
         end
         CAPFS_FN_CHARGER: begin
            st_next.pin_oe_n = 1'b0;
            st_next.pin_out  = core.charger_attached;
         end
         CAPFS_FN_CHARGER_N: begin
            st_next.pin_out  = 1'b0;
            st_next.pin_oe_n = !core.charger_attached;
         end
         CAPFS_FN_WRITE_STROBE_N: begin
            st_next.pin_oe_n = 1'b0;
            st_next.pin_out  = core.bitbang_write_strobe_n;
         end
         CAPFS_FN_READ_STROBE_N: begin
            st_next.pin_oe_n = 1'b0;
            st_next.pin_out  = core.bitbang_read_strobe_n;
         end
         CAPFS_FN_BUS_POWER: begin
            st_next.pin_oe_n = 1'b1;
         end
         CAPFS_FN_TIMESTAMP: begin
            st_next.pin_oe_n = 1'b0;
            st_next.pin_out  = st_next.stamp;
         end
         CAPFS_FN_STAY_AWAKE_N: begin
            st_next.pin_oe_n = 1'b1;
         end
      endcase
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg.func         <= CAPFS_FUNC_RST;
         st_reg.cancel_sleep <= CAPFS_CANCEL_RST;
         st_reg.gpio_en      <= CAPFS_GPIO_RST;
         st_reg.gpio_dir     <= CAPFS_GPIO_RST;
         st_reg.gpio_out     <= CAPFS_GPIO_RST;
         st_reg.stamp        <= 1'b0;
         st_reg.pin_out      <= 1'b0;
         st_reg.pin_oe_n     <= 1'b1;
         st_reg.bus_power    <= 1'b0;
         st_reg.suspended    <= 1'b0;
         st_reg.prdata       <= CAPFS_ZERO_WORD;
         st_reg.pslverr      <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign pready          = 1'b1;
   assign prdata          = st_reg.prdata;
   assign pslverr         = st_reg.pslverr;
   assign aux_pin_3_out   = st_reg.pin_out;
   assign aux_pin_3_oe_n  = st_reg.pin_oe_n;
   assign usb_suspended   = st_reg.suspended;
   assign bus_power_sense = st_reg.bus_power;

endmodule // capfs_aux_pin

// file: dv/capfs_aux_pin_assertions.sv
`timescale 1ns/1ps
// ========================================
// Pin function checker
module capfs_aux_pin_chk
   import capfs_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        usb_configured,
   input wire logic        usb_suspend_req,
   input wire logic        charger_attached,
   input wire logic        sof_pulse,
   input wire logic        clock_out_fast,
   input wire logic        bitbang_write_strobe_n,
   input wire logic        bitbang_read_strobe_n,
   input wire logic        aux_pin_3_out,
   input wire logic        aux_pin_3_oe_n
);
   // ========================================
   // Shadow of the selection register
   capfs_func_t func_q;
   logic        cancel_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_q   <= CAPFS_FUNC_RST;
         cancel_q <= CAPFS_CANCEL_RST;
      end else if (psel && penable && pwrite && paddr == CAPFS_FUNC_OFS) begin
         if (pstrb[0])
            func_q <= capfs_func_t'(pwdata[3:0]);
         if (pstrb[1])
            cancel_q <= pwdata[CAPFS_FUNC_CANCEL_BIT];
      end
   end

   // ========================================
   // Pin behaviour, one cycle behind its cause
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_pe_awake;
      func_q == CAPFS_FN_POWER_ENABLE_N && usb_configured && !usb_suspend_req;
   endsequence
   sequence s_ts_held;
      (func_q == CAPFS_FN_TIMESTAMP) [*2];
   endsequence

   property p_released;
      func_q inside {CAPFS_FN_TRISTATE, CAPFS_FN_BUS_POWER, CAPFS_FN_STAY_AWAKE_N}
         |=> aux_pin_3_oe_n;
   endproperty
   a_released: assert property (p_released) else $error("pin driven");
   property p_const;
      func_q inside {CAPFS_FN_DRIVE_ONE, CAPFS_FN_DRIVE_ZERO}
         |=> !aux_pin_3_oe_n && aux_pin_3_out == ($past(func_q) == CAPFS_FN_DRIVE_ONE);
   endproperty
   a_const: assert property (p_const) else $error("wrong constant");
   property p_pwr_on;
      s_pe_awake [*2] |=> !aux_pin_3_oe_n && !aux_pin_3_out;
   endproperty
   a_pwr_on: assert property (p_pwr_on) else $error("power enable not low");
   property p_sleep;
      (func_q == CAPFS_FN_SLEEP_N && $stable(usb_suspend_req)) [*2] |=> !aux_pin_3_oe_n
         && aux_pin_3_out == (!$past(usb_suspend_req) || ($past(cancel_q) && $past(charger_attached)));
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep level wrong");
   property p_clock;
      (func_q == CAPFS_FN_CLOCK_FAST && $stable(usb_suspend_req)) [*2] |=> !aux_pin_3_oe_n
         && aux_pin_3_out == ($past(clock_out_fast) && !$past(usb_suspend_req));
   endproperty
   a_clock: assert property (p_clock) else $error("clock output wrong");
   property p_strobe;
      func_q inside {CAPFS_FN_WRITE_STROBE_N, CAPFS_FN_READ_STROBE_N} |=> !aux_pin_3_oe_n
         && aux_pin_3_out == (($past(func_q) == CAPFS_FN_WRITE_STROBE_N) ?
            $past(bitbang_write_strobe_n) : $past(bitbang_read_strobe_n));
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe wrong");
   property p_charger_n;
      func_q == CAPFS_FN_CHARGER_N |=> aux_pin_3_oe_n == !$past(charger_attached)
         && (aux_pin_3_oe_n || !aux_pin_3_out);
   endproperty
   a_charger_n: assert property (p_charger_n) else $error("charger pull wrong");
   property p_charger;
      func_q == CAPFS_FN_CHARGER |=> !aux_pin_3_oe_n
         && aux_pin_3_out == $past(charger_attached);
   endproperty
   a_charger: assert property (p_charger) else $error("charger level wrong");
   property p_stamp;
      s_ts_held |=> aux_pin_3_out == ($past(aux_pin_3_out) ^ $past(sof_pulse));
   endproperty
   a_stamp: assert property (p_stamp) else $error("stamp toggle wrong");
endmodule // capfs_aux_pin_chk

bind capfs_aux_pin capfs_aux_pin_chk CHK (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .usb_configured(usb_configured), .usb_suspend_req(usb_suspend_req),
   .charger_attached(charger_attached), .sof_pulse(sof_pulse),
   .clock_out_fast(clock_out_fast), .bitbang_write_strobe_n(bitbang_write_strobe_n),
   .bitbang_read_strobe_n(bitbang_read_strobe_n), .aux_pin_3_out(aux_pin_3_out),
   .aux_pin_3_oe_n(aux_pin_3_oe_n));

// file: dv/capfs_pin_partner.sv
`timescale 1ns/1ps
// ========================================
// Far-side pin model with board pull-up
module capfs_pin_partner (
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   input  wire logic drive_en,
   input  wire logic drive_level,
   output      logic pin_level
);
   // Pull-up wins when nobody drives; a fight shows as unknown
   assign pin_level = (!pin_oe_n && drive_en) ? 1'bx :
                      !pin_oe_n ? pin_out : (drive_en ? drive_level : 1'b1);
endmodule // capfs_pin_partner

// file: dv/capfs_aux_pin_bench.sv
`timescale 1ns/1ps
// ========================================
// Pin function bench
module capfs_aux_pin_bench
   import capfs_pkg::*;
;
   capfs_apb_req_t req;
   logic           pclk, presetn, pready, pslverr, pin_lvl, pin_out, pin_oe_n, susp, bps;
   logic           cfg, sreq, chg, sof, cf, cm, cs, wr_n, rd_n, ext_en, ext_lvl, stamp, er;
   logic [31:0]    prdata, rd;
   int             num_errors, cmp_count, seed;

   capfs_aux_pin DUT (.pclk(pclk), .presetn(presetn), .psel(req.psel), .penable(req.penable),
      .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_configured(cfg),
      .usb_suspend_req(sreq), .charger_attached(chg), .sof_pulse(sof), .clock_out_fast(cf),
      .clock_out_mid(cm), .clock_out_slow(cs), .bitbang_write_strobe_n(wr_n),
      .bitbang_read_strobe_n(rd_n), .aux_pin_3_in(pin_lvl), .aux_pin_3_out(pin_out),
      .aux_pin_3_oe_n(pin_oe_n), .usb_suspended(susp), .bus_power_sense(bps));
   capfs_pin_partner PEER (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive_en(ext_en),
      .drive_level(ext_lvl), .pin_level(pin_lvl));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ========================================
   // Checking and bus tasks
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("comparisons=%0d mismatches=%0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] v, output logic e);
      int n;
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) begin
         num_errors++;
         test_done();
      end else begin
         v = prdata;
         e = pslverr;
         req <= '0;
         @(posedge pclk);
      end
   endtask

   task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      apb(1'b1, a, d, rd, er);
      apb(1'b0, a, CAPFS_ZERO_WORD, rd, er);
      check({er, rd}, {1'b0, d & m});
   endtask

   // ========================================
   // Pin model: {released, level}
   function automatic logic [1:0] exp_pin(input int f, input logic [11:0] g, input logic c);
      case (f)
         0, 13, 15: return 2'b10;
         1: return 2'b01;
         2: return 2'b00;
         3: return (cfg && !sreq) ? 2'b00 : 2'b10;
         4: return {1'b0, !sreq || (c && chg)};
         5, 6, 7: return {1'b0, !sreq && (f == 5 ? cf : (f == 6 ? cm : cs))};
         8: return (g[3] && g[7]) ? {1'b0, g[11]} : 2'b10;
         9: return {1'b0, chg};
         10: return chg ? 2'b00 : 2'b10;
         11, 12: return {1'b0, f == 11 ? wr_n : rd_n};
         default: return {1'b0, stamp ^ sof};
      endcase
   endfunction

   task automatic run_phase(input int f, input logic c, input logic s, input logic [11:0] g);
      logic [3:0]  e;
      logic [31:0] r;
      int          k;
      ext_en <= (f == 13 || f == 15);
      sreq <= s;
      for (k = 0; k < 14; k++) begin
         @(negedge pclk);
         // Early cycles still settle the new mode
         if (k > 3)
            check(33'({pin_oe_n, pin_out & !pin_oe_n, susp, bps}), 33'(e));
         if (k == 3)
            stamp = pin_out;
         e = {exp_pin(f, g, c), s && !(f == 15 && !ext_lvl), f == 13 && ext_lvl};
         stamp = stamp ^ (sof && f == 14);
         @(posedge pclk);
         r = $random(seed);
         {cfg, chg, sof, cf, cm, cs, wr_n, rd_n, ext_lvl} <= r[8:0];
      end
      // One edge so the registered status bits see the last inputs
      @(posedge pclk);
      apb(1'b0, CAPFS_STATUS_OFS, CAPFS_ZERO_WORD, r, er);
      check({er, r & 32'h0000_002E}, {1'b0, 26'h0, f == 15 && !ext_lvl, 1'b0, chg,
            f == 13 && ext_lvl, s && !(f == 15 && !ext_lvl), 1'b0});
   endtask

   // ========================================
   // Main sequence
   initial begin
      int          f, c, s;
      logic [31:0] r;
      {req, cfg, sreq, chg, sof, cf, cm, cs, wr_n, rd_n, ext_en, ext_lvl, stamp, er} = '0;
      seed = 15;
      num_errors = 0;
      cmp_count = 0;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h00C, CAPFS_ZERO_WORD, rd, er);
      check({er, rd}, {1'b1, CAPFS_ZERO_WORD});
      $display("unmapped access test done");
      for (f = 0; f < 16; f++) begin
         for (c = 0; c < 2; c++) begin
            for (s = 0; s < 2; s++) begin
               r = $random(seed);
               wr_rd(CAPFS_GPIO_OFS, r, 32'h0000_0FFF);
               wr_rd(CAPFS_FUNC_OFS, 32'(f) | (32'(c) << 8), 32'h0000_010F);
               run_phase(f, c[0], s[0], r[11:0]);
            end
         end
      end
      $display("pin function test done");
      test_done();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      test_done();
   end
endmodule // capfs_aux_pin_bench
